// ### ddr_cmd_decoder.sv
// Command decoder and per-bank legality checker for a DDR DRAM
`timescale 1ns/100ps
`default_nettype none
`include "ddr_cmd_defines.svh"
module ddr_cmd_decoder (
   // Device clock and reset
   input  wire logic                 I_CLK,
   input  wire logic                 I_RST,
   // Link clock for the command pins
   input  wire logic                 I_CK,
   // Command pins, active low strobes
   input  wire logic                 I_CKE,
   input  wire logic                 I_CS_N,
   input  wire logic                 I_RAS_N,
   input  wire logic                 I_CAS_N,
   input  wire logic                 I_WE_N,
   input  wire logic [`BANK_W-1:0]   I_BA,
   input  wire logic [`ADDR_W-1:0]   I_ADDR,
   input  wire logic                 I_ODT,
   // Decoded command
   output logic                      O_CMD_VALID,
   output var ddr_cmd_pkg::cmd_e     O_CMD,
   output logic [`BANK_W-1:0]        O_BANK,
   output logic [`ADDR_W-1:0]        O_ADDR,
   output logic                      O_AUTO_PRE,
   // Status
   output logic                      O_ILLEGAL,
   output logic [`BANK_CNT*3-1:0]    O_BANK_STATE,
   output logic                      O_POWER_DOWN,
   output logic                      O_SELF_REFRESH,
   output logic                      O_ODT_EN
);

   ////////////////////////////////////////////////////////////////////////////
   // Link side: pins captured on the link clock
   logic                 cke_prev_q;
   logic                 cke_now_q;
   logic                 cs_n_q;
   logic                 ras_n_q;
   logic                 cas_n_q;
   logic                 we_n_q;
   logic [`BANK_W-1:0]   ba_q;
   logic [`ADDR_W-1:0]   addr_q;
   logic                 ltog_q;

   // Pin sampling at the rising link edge
   always_ff @(posedge I_CK or posedge I_RST) begin
      if (I_RST) begin
         cke_prev_q <= 1'h0;
         cke_now_q  <= 1'h0;
         cs_n_q     <= 1'h1;
         ras_n_q    <= 1'h1;
         cas_n_q    <= 1'h1;
         we_n_q     <= 1'h1;
         ba_q       <= `BANK_W'(0);
         addr_q     <= `ADDR_W'(0);
      end else begin
         cke_prev_q <= cke_now_q;
         cke_now_q  <= I_CKE;
         cs_n_q     <= I_CS_N;
         ras_n_q    <= I_RAS_N;
         cas_n_q    <= I_CAS_N;
         we_n_q     <= I_WE_N;
         ba_q       <= I_BA;
         addr_q     <= I_ADDR;
      end
   end

   // Word holding register, stable for a link period; its toggle marks a new word
   logic [`BANK_W+`ADDR_W+5:0] hold_q;
   always_ff @(posedge I_CK or posedge I_RST) begin
      if (I_RST) begin
         hold_q <= '0;
         ltog_q <= 1'h0;
      end else begin
         hold_q <= {cke_prev_q, cke_now_q, cs_n_q, ras_n_q, cas_n_q, we_n_q, ba_q, addr_q};
         ltog_q <= ~ltog_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the device clock: toggle synchroniser
   logic tog_s1_q;
   logic tog_s2_q;
   logic tog_s3_q;
   logic new_word;
   logic [`BANK_W+`ADDR_W+5:0] word_q;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         tog_s1_q <= 1'h0;
         tog_s2_q <= 1'h0;
         tog_s3_q <= 1'h0;
      end else begin
         tog_s1_q <= ltog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end
   end

   assign new_word = tog_s2_q ^ tog_s3_q;

   // Word is taken once its toggle has settled
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         word_q <= '0;
      end else if (new_word) begin
         word_q <= hold_q;
      end
   end

   logic                 w_go;
   logic                 w_ckep;
   logic                 w_cken;
   logic                 w_cs_n;
   logic                 w_ras_n;
   logic                 w_cas_n;
   logic                 w_we_n;
   logic [`BANK_W-1:0]   w_ba;
   logic [`ADDR_W-1:0]   w_addr;
   logic                 go_q;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         go_q <= 1'h0;
      end else begin
         go_q <= new_word;
      end
   end

   assign w_go = go_q;
   assign {w_ckep, w_cken, w_cs_n, w_ras_n, w_cas_n, w_we_n, w_ba, w_addr} = word_q;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode from the strobe levels
   ddr_cmd_pkg::cmd_e cmd;
   logic              is_nop;
   logic [`BANK_W-1:0] bank_sel;
   ddr_cmd_pkg::pwr_e pwr_q;
   logic [`TMR_W-1:0] glob_q;

   assign is_nop = w_cs_n | (w_ras_n & w_cas_n & w_we_n);

   // Third bank bit only kept for large parts
   assign bank_sel = {w_ba[`BANK_W-1] & `BIG_DENSITY, w_ba[`BANK_W-2:0]};

   always_comb begin
      cmd = ddr_cmd_pkg::CMD_RSVD;
      if (!w_ckep) begin
         // CKE was low: only an exit with NOP is meaningful
         if (w_cken && is_nop) begin
            cmd = (pwr_q == ddr_cmd_pkg::PW_SREF) ? ddr_cmd_pkg::CMD_SRX
                                                  : ddr_cmd_pkg::CMD_PDX;
         end else if (!w_cken) begin
            cmd = ddr_cmd_pkg::CMD_NOP;
         end
      end else if (w_cs_n) begin
         cmd = w_cken ? ddr_cmd_pkg::CMD_DESEL : ddr_cmd_pkg::CMD_PDE;
      end else begin
         case ({w_ras_n, w_cas_n, w_we_n})
            3'h7: cmd = w_cken ? ddr_cmd_pkg::CMD_NOP : ddr_cmd_pkg::CMD_PDE;
            3'h0: cmd = w_cken ? ddr_cmd_pkg::CMD_MRS : ddr_cmd_pkg::CMD_RSVD;
            3'h1: cmd = w_cken ? ddr_cmd_pkg::CMD_REF : ddr_cmd_pkg::CMD_SREF;
            3'h2: begin
               if (!w_cken) cmd = ddr_cmd_pkg::CMD_RSVD;
               else if (w_addr[`A10_POS]) cmd = ddr_cmd_pkg::CMD_PREA;
               else cmd = ddr_cmd_pkg::CMD_PRE;
            end
            3'h3: cmd = w_cken ? ddr_cmd_pkg::CMD_ACT : ddr_cmd_pkg::CMD_RSVD;
            3'h5: begin
               if (!w_cken) cmd = ddr_cmd_pkg::CMD_RSVD;
               else if (w_addr[`A10_POS]) cmd = ddr_cmd_pkg::CMD_RDA;
               else cmd = ddr_cmd_pkg::CMD_RD;
            end
            3'h4: begin
               if (!w_cken) cmd = ddr_cmd_pkg::CMD_RSVD;
               else if (w_addr[`A10_POS]) cmd = ddr_cmd_pkg::CMD_WRA;
               else cmd = ddr_cmd_pkg::CMD_WR;
            end
            default: cmd = ddr_cmd_pkg::CMD_RSVD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state and exit delay

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pwr_q <= ddr_cmd_pkg::PW_ACTIVE;
      end else if (w_go) begin
         case (cmd)
            ddr_cmd_pkg::CMD_PDE:  pwr_q <= ddr_cmd_pkg::PW_PDOWN;
            ddr_cmd_pkg::CMD_SREF: pwr_q <= ddr_cmd_pkg::PW_SREF;
            ddr_cmd_pkg::CMD_PDX:  pwr_q <= ddr_cmd_pkg::PW_ACTIVE;
            ddr_cmd_pkg::CMD_SRX:  pwr_q <= ddr_cmd_pkg::PW_XWAIT;
            default:               pwr_q <= pwr_q;
         endcase
      end else if (pwr_q == ddr_cmd_pkg::PW_XWAIT && glob_q == `TMR_ZERO) begin
         pwr_q <= ddr_cmd_pkg::PW_ACTIVE;
      end
   end

   // Global busy timer: refresh, mode load, self refresh exit
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         glob_q <= `TMR_ZERO;
      end else if (w_go && cmd == ddr_cmd_pkg::CMD_REF) begin
         glob_q <= `TMR_W'(`TRFC_CYC);
      end else if (w_go && cmd == ddr_cmd_pkg::CMD_MRS) begin
         glob_q <= `TMR_W'(`TMRD_CYC);
      end else if (w_go && cmd == ddr_cmd_pkg::CMD_SRX) begin
         glob_q <= `TMR_W'(`TXSNR_CYC);
      end else if (glob_q != `TMR_ZERO) begin
         glob_q <= glob_q - `TMR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-bank trackers
   ddr_cmd_pkg::bank_e bst [`BANK_CNT];
   logic               all_idle;
   logic [`BANK_CNT-1:0] idle_v;
   logic [`BANK_CNT-1:0] bgo;
   logic               accept;

   genvar gi;
   generate
      for (gi = 0; gi < `BANK_CNT; gi++) begin : g_bank
         // Bank command goes only to the selected bank or all for precharge all
         assign bgo[gi] = accept && (cmd == ddr_cmd_pkg::CMD_PREA ||
                                     (bank_sel == `BANK_W'(gi) && !is_nop));
         assign idle_v[gi] = (bst[gi] == ddr_cmd_pkg::BK_IDLE);
         assign O_BANK_STATE[gi*3 +: 3] = bst[gi];
         ddr_bank_fsm u_bank (
            .i_clk   (I_CLK),
            .i_rst   (I_RST),
            .i_go    (bgo[gi]),
            .i_cmd   (cmd),
            .o_state (bst[gi])
         );
      end
   endgenerate

   assign all_idle = &idle_v;

   ////////////////////////////////////////////////////////////////////////////
   // Legality of a command for the addressed bank
   logic               legal;
   ddr_cmd_pkg::bank_e tgt;

   assign tgt = bst[bank_sel];

   always_comb begin
      legal = 1'h0;
      case (cmd)
         ddr_cmd_pkg::CMD_DESEL, ddr_cmd_pkg::CMD_NOP,
         ddr_cmd_pkg::CMD_PDE, ddr_cmd_pkg::CMD_PDX,
         ddr_cmd_pkg::CMD_SRX:
            legal = 1'h1;
         ddr_cmd_pkg::CMD_MRS, ddr_cmd_pkg::CMD_REF, ddr_cmd_pkg::CMD_SREF:
            legal = all_idle;
         ddr_cmd_pkg::CMD_ACT:
            legal = (tgt == ddr_cmd_pkg::BK_IDLE);
         ddr_cmd_pkg::CMD_RD, ddr_cmd_pkg::CMD_RDA,
         ddr_cmd_pkg::CMD_WR, ddr_cmd_pkg::CMD_WRA,
         ddr_cmd_pkg::CMD_PRE:
            legal = (tgt == ddr_cmd_pkg::BK_ACTV) ||
                    (tgt == ddr_cmd_pkg::BK_READ) ||
                    (tgt == ddr_cmd_pkg::BK_WRITE);
         ddr_cmd_pkg::CMD_PREA:
            legal = 1'h1;
         default:
            legal = 1'h0;
      endcase
      // Bank rules only in a settled powered state
      if (glob_q != `TMR_ZERO && !is_nop) begin
         legal = 1'h0;
      end
      if (pwr_q == ddr_cmd_pkg::PW_XWAIT && !is_nop) begin
         legal = 1'h0;
      end
   end

   assign accept = w_go && legal;

   ////////////////////////////////////////////////////////////////////////////
   // Registered decode outputs
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CMD_VALID <= 1'h0;
         O_CMD       <= ddr_cmd_pkg::CMD_DESEL;
         O_BANK      <= `BANK_W'(0);
         O_ADDR      <= `ADDR_W'(0);
         O_AUTO_PRE  <= 1'h0;
         O_ILLEGAL   <= 1'h0;
      end else begin
         O_CMD_VALID <= w_go;
         O_ILLEGAL   <= w_go && !legal;
         if (w_go) begin
            O_CMD      <= cmd;
            O_BANK     <= bank_sel;
            O_ADDR     <= w_addr;
            O_AUTO_PRE <= w_addr[`A10_POS];
         end
      end
   end

   // Power state outputs and termination gate
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_POWER_DOWN   <= 1'h0;
         O_SELF_REFRESH <= 1'h0;
      end else begin
         O_POWER_DOWN   <= (pwr_q == ddr_cmd_pkg::PW_PDOWN);
         O_SELF_REFRESH <= (pwr_q == ddr_cmd_pkg::PW_SREF);
      end
   end

   // Termination pin crossed, never feeds decode
   logic odt_s1_q;
   logic odt_s2_q;
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         odt_s1_q <= 1'h0;
         odt_s2_q <= 1'h0;
         O_ODT_EN <= 1'h0;
      end else begin
         odt_s1_q <= I_ODT;
         odt_s2_q <= odt_s1_q;
         O_ODT_EN <= odt_s2_q && (pwr_q != ddr_cmd_pkg::PW_SREF);
      end
   end

endmodule
`default_nettype wire

// ### ddr_cmd_defines.svh
// Constants for the DRAM command decoder
`ifndef DDR_CMD_DEFINES_SVH
`define DDR_CMD_DEFINES_SVH

`define BANK_CNT       8
`define BANK_W         3
`define ADDR_W         14
`define A10_POS        10
`define TRP_NS         12
`define TRCD_NS        12
`define TMRD_NS        20
`define TRFC_NS        128
`define TXSNR_NS       138
`define BURST_NS       40
`define CLK_NS         10
`define TRP_CYC        ((`TRP_NS + `CLK_NS - 1) / `CLK_NS)
`define TRCD_CYC       ((`TRCD_NS + `CLK_NS - 1) / `CLK_NS)
`define TMRD_CYC       ((`TMRD_NS + `CLK_NS - 1) / `CLK_NS)
`define TRFC_CYC       ((`TRFC_NS + `CLK_NS - 1) / `CLK_NS)
`define TXSNR_CYC      ((`TXSNR_NS + `CLK_NS - 1) / `CLK_NS)
`define BURST_CYC      ((`BURST_NS + `CLK_NS - 1) / `CLK_NS)
`define TMR_W          5
`define TMR_ZERO       5'h00
`define BIG_DENSITY    1'h1

`endif

// ### ddr_cmd_pkg.sv
// Types for the DRAM command decoder
package ddr_cmd_pkg;
   typedef enum logic [3:0] {
      CMD_DESEL = 4'h0,
      CMD_NOP   = 4'h1,
      CMD_MRS   = 4'h2,
      CMD_REF   = 4'h3,
      CMD_SREF  = 4'h4,
      CMD_PRE   = 4'h5,
      CMD_PREA  = 4'h6,
      CMD_ACT   = 4'h7,
      CMD_RD    = 4'h8,
      CMD_RDA   = 4'h9,
      CMD_WR    = 4'hA,
      CMD_WRA   = 4'hB,
      CMD_PDE   = 4'hC,
      CMD_PDX   = 4'hD,
      CMD_SRX   = 4'hE,
      CMD_RSVD  = 4'hF
   } cmd_e;

   typedef enum logic [2:0] {
      BK_IDLE   = 3'h0,
      BK_OPEN   = 3'h1,
      BK_ACTV   = 3'h2,
      BK_READ   = 3'h3,
      BK_WRITE  = 3'h4,
      BK_PRECH  = 3'h5,
      BK_RDAP   = 3'h6,
      BK_WRAP   = 3'h7
   } bank_e;

   typedef enum logic [1:0] {
      PW_ACTIVE = 2'h0,
      PW_PDOWN  = 2'h1,
      PW_SREF   = 2'h2,
      PW_XWAIT  = 2'h3
   } pwr_e;
endpackage

// ### ddr_bank_fsm.sv
// One bank's state tracker with timers
`timescale 1ns/100ps
`default_nettype none
`include "ddr_cmd_defines.svh"
module ddr_bank_fsm (
   // Clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   // Command to this bank
   input  wire logic               i_go,
   input  wire ddr_cmd_pkg::cmd_e  i_cmd,
   // Bank state
   output var ddr_cmd_pkg::bank_e  o_state
);

   ddr_cmd_pkg::bank_e state_q;
   logic [`TMR_W-1:0]  tmr_q;

   assign o_state = state_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bank state walk
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ddr_cmd_pkg::BK_IDLE;
         tmr_q   <= `TMR_ZERO;
      end else if (i_go) begin
         case (i_cmd)
            ddr_cmd_pkg::CMD_ACT: begin
               state_q <= ddr_cmd_pkg::BK_OPEN;
               tmr_q   <= `TMR_W'(`TRCD_CYC);
            end
            ddr_cmd_pkg::CMD_RD: begin
               state_q <= ddr_cmd_pkg::BK_READ;
               tmr_q   <= `TMR_W'(`BURST_CYC);
            end
            ddr_cmd_pkg::CMD_WR: begin
               state_q <= ddr_cmd_pkg::BK_WRITE;
               tmr_q   <= `TMR_W'(`BURST_CYC);
            end
            ddr_cmd_pkg::CMD_RDA: begin
               state_q <= ddr_cmd_pkg::BK_RDAP;
               tmr_q   <= `TMR_W'(`BURST_CYC + `TRP_CYC);
            end
            ddr_cmd_pkg::CMD_WRA: begin
               state_q <= ddr_cmd_pkg::BK_WRAP;
               tmr_q   <= `TMR_W'(`BURST_CYC + `TRP_CYC);
            end
            ddr_cmd_pkg::CMD_PRE, ddr_cmd_pkg::CMD_PREA: begin
               state_q <= ddr_cmd_pkg::BK_PRECH;
               tmr_q   <= `TMR_W'(`TRP_CYC);
            end
            default: begin
               state_q <= state_q;
               tmr_q   <= tmr_q;
            end
         endcase
      end else if (tmr_q > `TMR_W'(1)) begin
         tmr_q <= tmr_q - `TMR_W'(1);
      end else if (tmr_q == `TMR_W'(1)) begin
         tmr_q <= `TMR_ZERO;
         case (state_q)
            ddr_cmd_pkg::BK_OPEN,
            ddr_cmd_pkg::BK_READ,
            ddr_cmd_pkg::BK_WRITE: state_q <= ddr_cmd_pkg::BK_ACTV;
            ddr_cmd_pkg::BK_PRECH,
            ddr_cmd_pkg::BK_RDAP,
            ddr_cmd_pkg::BK_WRAP:  state_q <= ddr_cmd_pkg::BK_IDLE;
            default:               state_q <= state_q;
         endcase
      end
   end

endmodule
`default_nettype wire

// ### ddr_ctrl_model.sv
// Memory controller model driving the command pins on the link clock
`timescale 1ns/100ps
`default_nettype none
`include "ddr_cmd_defines.svh"
module ddr_ctrl_model (
   // Link clock and reset
   input  wire logic               i_ck,
   input  wire logic               i_rst,
   // Toggle request from the bench
   input  wire logic               i_req,
   input  wire logic               i_cke,
   input  wire logic [3:0]         i_pins,
   input  wire logic [`BANK_W-1:0] i_ba,
   input  wire logic [`ADDR_W-1:0] i_addr,
   output logic                    o_ack,
   // Command pins
   output logic                    o_cke,
   output logic                    o_cs_n,
   output logic                    o_ras_n,
   output logic                    o_cas_n,
   output logic                    o_we_n,
   output logic [`BANK_W-1:0]      o_ba,
   output logic [`ADDR_W-1:0]      o_addr
);
   ////////////////////////////////////////////////////////////////////////////
   // One word per link edge, a request once and NOP otherwise
   always_ff @(posedge i_ck or posedge i_rst) begin
      if (i_rst) begin
         o_ack <= 1'h0;
         o_cke <= 1'h0;
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'h7;
         o_ba <= 3'h0;
         o_addr <= 14'h0000;
      end else begin
         o_cke <= i_cke;
         if (i_req != o_ack) begin
            o_ack <= i_req;
            {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= i_pins;
            o_ba <= i_ba;
            o_addr <= i_addr;
         end else begin
            {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'h7;
            o_ba <= ~o_ba; // Idle lines move
            o_addr <= ~o_addr;
         end
      end
   end
endmodule
`default_nettype wire

// ### ddr_cmd_decoder_props.sv
// Assertions on the DRAM command decoder ports
`timescale 1ns/100ps
`default_nettype none
`include "ddr_cmd_defines.svh"
module ddr_cmd_decoder_props (
   // Clock and reset
   input  wire logic                 I_CLK,
   input  wire logic                 I_RST,
   // Decoder outputs
   input  wire logic                 O_CMD_VALID,
   input  wire ddr_cmd_pkg::cmd_e    O_CMD,
   input  wire logic [`BANK_W-1:0]   O_BANK,
   input  wire logic [`ADDR_W-1:0]   O_ADDR,
   input  wire logic                 O_AUTO_PRE,
   input  wire logic                 O_ILLEGAL,
   input  wire logic [`BANK_CNT*3-1:0] O_BANK_STATE,
   input  wire logic                 O_POWER_DOWN,
   input  wire logic                 O_SELF_REFRESH,
   input  wire logic                 O_ODT_EN
);
   ////////////////////////////////////////////////////////////////////////////
   // All checks on the device clock
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   AST_ILL_WITH_VALID: assert property (O_ILLEGAL |-> O_CMD_VALID)
      else $error("illegal flag outside a command pulse");
   AST_VALID_PULSE: assert property (O_CMD_VALID |=> !O_CMD_VALID [*3])
      else $error("command pulses too close");
   AST_NOP_LEGAL: assert property (O_CMD_VALID && O_CMD inside {ddr_cmd_pkg::CMD_DESEL,
      ddr_cmd_pkg::CMD_NOP} |-> !O_ILLEGAL) else $error("no-operation flagged");
   AST_AUTO_PRE: assert property (O_CMD_VALID && O_CMD inside {ddr_cmd_pkg::CMD_RD,
      ddr_cmd_pkg::CMD_RDA, ddr_cmd_pkg::CMD_WR, ddr_cmd_pkg::CMD_WRA} |-> O_AUTO_PRE ==
      O_ADDR[`A10_POS] && O_AUTO_PRE == (O_CMD inside {ddr_cmd_pkg::CMD_RDA,
      ddr_cmd_pkg::CMD_WRA})) else $error("auto precharge mismatch");
   AST_PRE_KIND: assert property (O_CMD_VALID && O_CMD inside {ddr_cmd_pkg::CMD_PRE,
      ddr_cmd_pkg::CMD_PREA} |-> O_ADDR[`A10_POS] == (O_CMD == ddr_cmd_pkg::CMD_PREA))
      else $error("precharge kind mismatch");
   AST_ACT_OPENS: assert property (O_CMD_VALID && O_CMD == ddr_cmd_pkg::CMD_ACT &&
      !O_ILLEGAL |-> ##[0:4] O_BANK_STATE[O_BANK*3 +: 3] == ddr_cmd_pkg::BK_ACTV)
      else $error("bank not active after activate");
   AST_PRE_CLOSES: assert property (O_CMD_VALID && O_CMD == ddr_cmd_pkg::CMD_PRE &&
      !O_ILLEGAL |-> ##[1:4] O_BANK_STATE[O_BANK*3 +: 3] == ddr_cmd_pkg::BK_IDLE)
      else $error("bank not idle after precharge");
   AST_SREF_SETS: assert property (O_CMD_VALID && O_CMD == ddr_cmd_pkg::CMD_SREF
      |-> ##[0:2] O_SELF_REFRESH) else $error("self refresh not entered");
   AST_PD_SETS: assert property (O_CMD_VALID && O_CMD == ddr_cmd_pkg::CMD_PDE
      |-> ##[0:2] O_POWER_DOWN) else $error("power-down not entered");
   AST_ODT_GATED: assert property (O_SELF_REFRESH [*3] |-> !O_ODT_EN)
      else $error("termination on in self refresh");
endmodule
bind ddr_cmd_decoder ddr_cmd_decoder_props u_ddr_cmd_decoder_props (.I_CLK, .I_RST,
   .O_CMD_VALID, .O_CMD, .O_BANK, .O_ADDR, .O_AUTO_PRE, .O_ILLEGAL, .O_BANK_STATE,
   .O_POWER_DOWN, .O_SELF_REFRESH, .O_ODT_EN);
`default_nettype wire

// ### tb_top.sv
// Testbench for the DRAM command decoder
`timescale 1ns/100ps
`default_nettype none
`include "ddr_cmd_defines.svh"
module tb_top;
   // Clocks, reset, pins and bench state
   logic                  I_CLK = 1'b0;
   logic                  I_CK = 1'b0;
   logic                  I_RST;
   logic                  I_ODT = 1'b0;
   logic                  req = 1'b0, req_cke = 1'b1, ack;
   logic [3:0]            req_pins = 4'h7;
   logic [2:0]            req_ba = 3'h0, ba;
   logic [13:0]           req_addr = 14'h0000, addr, o_addr;
   logic                  cke, cs_n, ras_n, cas_n, we_n;
   logic                  cmd_valid, auto_pre, illegal, power_down, self_refresh, odt_en;
   logic [2:0]            bank;
   logic [23:0]           bank_state;
   ddr_cmd_pkg::cmd_e     cmd;
   int                    n_fail = 0, n_compared = 0;
   localparam logic [3:0] p_mrs = 4'h0, p_ref = 4'h1, p_pre = 4'h2, p_act = 4'h3;
   localparam logic [3:0] p_wr = 4'h4, p_rd = 4'h5, p_nop = 4'h7, p_des = 4'hF;

   // Device clock and free-running link clock
   always #5 I_CLK = ~I_CLK;
   always #32 I_CK = ~I_CK;

   ddr_ctrl_model u_ddr_ctrl_model (.i_ck(I_CK), .i_rst(I_RST), .i_req(req), .i_cke(req_cke),
      .i_pins(req_pins), .i_ba(req_ba), .i_addr(req_addr), .o_ack(ack), .o_cke(cke),
      .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
   ddr_cmd_decoder u_ddr_cmd_decoder (.I_CLK(I_CLK), .I_RST(I_RST), .I_CK(I_CK), .I_CKE(cke),
      .I_CS_N(cs_n), .I_RAS_N(ras_n), .I_CAS_N(cas_n), .I_WE_N(we_n), .I_BA(ba), .I_ADDR(addr),
      .I_ODT(I_ODT), .O_CMD_VALID(cmd_valid), .O_CMD(cmd), .O_BANK(bank), .O_ADDR(o_addr),
      .O_AUTO_PRE(auto_pre), .O_ILLEGAL(illegal), .O_BANK_STATE(bank_state),
      .O_POWER_DOWN(power_down), .O_SELF_REFRESH(self_refresh), .O_ODT_EN(odt_en));

   ////////////////////////////////////////////////////////////////////////////
   // Compare helpers and verdict
   task automatic chk_cmd(input ddr_cmd_pkg::cmd_e e, input ddr_cmd_pkg::cmd_e g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected command at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_val(input logic [23:0] e, input logic [23:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected value at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Hands one word to the model and judges its decoded pulse
   task automatic send(input logic c, input logic [3:0] p, input logic [2:0] b,
                       input logic [13:0] a, input ddr_cmd_pkg::cmd_e e, input logic il);
      int n;
      @(posedge I_CLK);
      req_cke <= c;
      req_pins <= p;
      req_ba <= b;
      req_addr <= a;
      req <= ~req;
      @(posedge I_CLK);
      n = 0;
      while (ack !== req && n < 40) begin
         @(posedge I_CLK);
         n++;
      end
      n = 0;
      do begin
         @(posedge I_CLK);
         #1;
         n++;
      end while (!(cmd_valid === 1'b1 && cmd === e) && n < 60);
      chk_cmd(e, cmd);
      chk_val(24'(il), 24'(illegal));
      if (p inside {p_act, p_rd, p_wr, p_mrs}) chk_val(24'(b), 24'(bank));
      if (p inside {p_rd, p_wr}) chk_val(24'(a[10]), 24'(auto_pre));
   endtask
   task automatic wait_bank(input int b, input ddr_cmd_pkg::bank_e e, input int lim);
      int n;
      n = 0;
      while (bank_state[b*3 +: 3] !== e && n < lim) begin
         @(posedge I_CLK);
         #1;
         n++;
      end
      chk_val(24'(e), 24'(bank_state[b*3 +: 3]));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      chk_val(24'h000000, bank_state);
      chk_val(24'({power_down, self_refresh, odt_en}), 24'h0);
   endtask
   task automatic t_open_close;
      send(1'b1, p_act, 3'h2, 14'h1ABC, ddr_cmd_pkg::CMD_ACT, 1'b0);
      wait_bank(2, ddr_cmd_pkg::BK_ACTV, 8);
      send(1'b1, p_rd, 3'h2, 14'h0010, ddr_cmd_pkg::CMD_RD, 1'b0);
      wait_bank(2, ddr_cmd_pkg::BK_READ, 3);
      wait_bank(2, ddr_cmd_pkg::BK_ACTV, 10);
      send(1'b1, p_wr, 3'h2, 14'h0020, ddr_cmd_pkg::CMD_WR, 1'b0);
      wait_bank(2, ddr_cmd_pkg::BK_WRITE, 3);
      send(1'b1, p_rd, 3'h2, 14'h0030, ddr_cmd_pkg::CMD_RD, 1'b0);
      send(1'b1, p_pre, 3'h2, 14'h0000, ddr_cmd_pkg::CMD_PRE, 1'b0);
      wait_bank(2, ddr_cmd_pkg::BK_IDLE, 10);
   endtask
   task automatic t_illegal;
      send(1'b1, p_rd, 3'h5, 14'h0000, ddr_cmd_pkg::CMD_RD, 1'b1);
      send(1'b1, p_wr, 3'h5, 14'h0400, ddr_cmd_pkg::CMD_WRA, 1'b1);
      wait_bank(5, ddr_cmd_pkg::BK_IDLE, 1);
      send(1'b1, p_act, 3'h4, 14'h0001, ddr_cmd_pkg::CMD_ACT, 1'b0);
      send(1'b1, p_ref, 3'h0, 14'h0000, ddr_cmd_pkg::CMD_REF, 1'b1);
      send(1'b1, p_nop, 3'h4, 14'h0000, ddr_cmd_pkg::CMD_NOP, 1'b0);
      wait_bank(4, ddr_cmd_pkg::BK_ACTV, 1);
      send(1'b1, p_pre, 3'h4, 14'h0000, ddr_cmd_pkg::CMD_PRE, 1'b0);
      wait_bank(4, ddr_cmd_pkg::BK_IDLE, 10);
   endtask
   task automatic t_autopre;
      send(1'b1, p_act, 3'h7, 14'h2001, ddr_cmd_pkg::CMD_ACT, 1'b0);
      send(1'b1, p_rd, 3'h7, 14'h0408, ddr_cmd_pkg::CMD_RDA, 1'b0);
      wait_bank(7, ddr_cmd_pkg::BK_IDLE, 20);
      send(1'b1, p_act, 3'h7, 14'h2002, ddr_cmd_pkg::CMD_ACT, 1'b0);
      send(1'b1, p_wr, 3'h7, 14'h0404, ddr_cmd_pkg::CMD_WRA, 1'b0);
      wait_bank(7, ddr_cmd_pkg::BK_IDLE, 20);
   endtask
   task automatic t_prea;
      send(1'b1, p_act, 3'h1, 14'h0011, ddr_cmd_pkg::CMD_ACT, 1'b0);
      send(1'b1, p_act, 3'h3, 14'h0033, ddr_cmd_pkg::CMD_ACT, 1'b0);
      send(1'b1, p_pre, 3'h1, 14'h0400, ddr_cmd_pkg::CMD_PREA, 1'b0);
      wait_bank(1, ddr_cmd_pkg::BK_IDLE, 10);
      wait_bank(3, ddr_cmd_pkg::BK_IDLE, 10);
   endtask
   task automatic t_mode_refresh;
      send(1'b1, p_ref, 3'h6, 14'h3FFF, ddr_cmd_pkg::CMD_REF, 1'b0);
      repeat (16) @(posedge I_CLK);
      send(1'b1, p_mrs, 3'h2, 14'h0642, ddr_cmd_pkg::CMD_MRS, 1'b0);
      chk_val(24'h000642, 24'(o_addr));
      repeat (4) @(posedge I_CLK);
   endtask
   task automatic t_selfref;
      I_ODT <= 1'b1;
      repeat (8) @(posedge I_CLK);
      chk_val(24'h1, 24'(odt_en));
      send(1'b0, p_ref, 3'h0, 14'h0000, ddr_cmd_pkg::CMD_SREF, 1'b0);
      repeat (3) @(posedge I_CLK);
      chk_val(24'h1, 24'(self_refresh));
      chk_val(24'h0, 24'(odt_en));
      send(1'b1, p_nop, 3'h0, 14'h0000, ddr_cmd_pkg::CMD_SRX, 1'b0);
      repeat (16) @(posedge I_CLK);
      chk_val(24'h0, 24'(self_refresh));
      I_ODT <= 1'b0;
      send(1'b1, p_act, 3'h0, 14'h0100, ddr_cmd_pkg::CMD_ACT, 1'b0);
      send(1'b1, p_pre, 3'h0, 14'h0000, ddr_cmd_pkg::CMD_PRE, 1'b0);
   endtask
   task automatic t_pdown;
      send(1'b0, p_nop, 3'h0, 14'h0000, ddr_cmd_pkg::CMD_PDE, 1'b0);
      repeat (3) @(posedge I_CLK);
      chk_val(24'h1, 24'(power_down));
      send(1'b1, p_des, 3'h0, 14'h0000, ddr_cmd_pkg::CMD_PDX, 1'b0);
      repeat (3) @(posedge I_CLK);
      chk_val(24'h0, 24'(power_down));
      send(1'b1, p_des, 3'h3, 14'h0000, ddr_cmd_pkg::CMD_DESEL, 1'b0);
   endtask

   // Main sequence
   initial begin
      I_RST <= 1'h1;
      repeat (4) @(posedge I_CLK);
      I_RST <= 1'h0;
      repeat (14) @(posedge I_CLK);
      t_reset();
      t_open_close();
      t_illegal();
      t_autopre();
      t_prea();
      t_mode_refresh();
      t_selfref();
      t_pdown();
      final_report();
   end

   // Watchdog against a hang
   initial begin
      #200000;
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
